// ===== bench/pcmhc_mem_model.sv
`timescale 1ns/100ps
// ----
// Memory device model
// ----
module pcmhc_mem_model
    import pcmhc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic [22:0] a_i,
    input  wire logic [15:0] d_i,
    output logic      [15:0] q_o
);
    logic [7:0]  sr = 8'h00, last = 8'h00, cntb = 8'h00, left = 8'h00;
    logic [15:0] drv = 16'h0000;
    logic        weq = 1'b1, oeq = 1'b1, tog = 1'b0, sm = 1'b0, cnx = 1'b0;
    logic        ers = 1'b0, fail_nx = 1'b0;
    int          busy = 0, nwr = 0, nwords = 0, nclr = 0;
    wire  [7:0]  c = d_i[7:0];
    // A released bus flips every cycle, so stale data never looks valid.
    assign q_o = oe_n_i ? {16{tog}} : drv;
    // Command decoder; busy counts down the time of the internal operation.
    always @(posedge clk_i) begin
        tog <= ~tog;
        weq <= we_n_i;
        oeq <= oe_n_i;
        if (busy != 0) busy <= busy - 1;
        if (!oe_n_i && oeq) drv <= sm ? {8'h00, busy == 0, sr[6:0]} : a_i[15:0] ^ 16'h5555;
        if (we_n_i && !weq && !ce_n_i) begin
            nwr <= nwr + 1;
            last <= c;
            if (left != 8'h00) begin
                left <= left - 8'h01;
                nwords <= nwords + 1;
                busy <= 6;
                sr[4] <= sr[4] | fail_nx;
                fail_nx <= 1'b0;
            end else if (cnx) begin
                cntb <= c;
                left <= c + 8'h01;
                cnx <= 1'b0;
            end else begin
                sm <= c != CMD_READ_ARRAY;
                cnx <= c == CMD_BUF_PROG || c == CMD_BUF_ALT;
                if (c == CMD_WORD_PROG || c == CMD_WORD_ALT || c == CMD_OTP_PROG) left <= 8'h01;
                if (c == CMD_ERASE) ers <= 1'b1;
                if (c == CMD_CONFIRM) busy <= sr[6] ? 40 : (ers ? 3000 : 6);
                if (c == CMD_CONFIRM) sr[6] <= 1'b0;
                if (c == CMD_CONFIRM && sr[6]) ers <= 1'b0;
                if (c == CMD_SUSPEND && ers && busy != 0) begin
                    sr[6] <= 1'b1;
                    busy <= 0;
                end
                if (c == CMD_CLEAR_STATUS) sr <= sr & ~SR_ERR_MASK;
                nclr <= nclr + int'(c == CMD_CLEAR_STATUS);
            end
        end
    end
endmodule

// ===== bench/pcmhc_seq_assertions.sv
`timescale 1ns/100ps
// ----
// Bus and command port checks
// ----
module pcmhc_seq_assertions
    import pcmhc_pkg::*;
#(
    parameter int unsigned POLL_LIMIT = POLL_LIMIT_DEF
)(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       en_i,
    input wire logic       cmd_valid_i,
    input wire pcmhc_cmd_s cmd_i,
    input wire logic       cmd_ready_o,
    input wire logic       done_o,
    input wire pcmhc_res_s res_o,
    input wire logic       ce_n_o,
    input wire logic       oe_n_o,
    input wire logic       we_n_o,
    input wire logic       dq_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A buffered program with an oversized count is offered and taken.
    wire big = en_i && cmd_valid_i && cmd_ready_o && cmd_i.op == OP_BUF_PROG
               && cmd_i.count > BUF_MAX_COUNT;
    a_strobe_apart: assert property (we_n_o || oe_n_o)
        else $error("strobes overlap");
    a_write_drive: assert property (!we_n_o |-> !ce_n_o && !dq_oe_n_o)
        else $error("bad write cycle");
    a_read_release: assert property (!oe_n_o |-> !ce_n_o && dq_oe_n_o)
        else $error("bad read cycle");
    a_write_width: assert property ($fell(we_n_o) |-> !we_n_o [*8] ##1 we_n_o)
        else $error("write pulse width");
    a_read_width: assert property ($fell(oe_n_o) |-> ##17 !oe_n_o ##1 oe_n_o)
        else $error("read pulse width");
    a_fresh_strobe: assert property ($rose(ce_n_o) |=> ce_n_o)
        else $error("select not released");
    a_done_pulse: assert property (done_o |=> !done_o)
        else $error("done too long");
    a_ready_done: assert property ($rose(cmd_ready_o) |-> done_o)
        else $error("ready without done");
    a_count_refused: assert property (big |-> ##[1:2] (done_o && res_o.rejected && ce_n_o))
        else $error("count not refused");
endmodule
bind pcmhc_seq pcmhc_seq_assertions #(.POLL_LIMIT(POLL_LIMIT)) pcmhc_seq_assertions_inst (
    .clk_i, .rst_i, .en_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .done_o, .res_o,
    .ce_n_o, .oe_n_o, .we_n_o, .dq_oe_n_o);

// ===== bench/pcmhc_seq_tb.sv
`timescale 1ns/100ps
// ----
// Command level test of the sequencer
// ----
module pcmhc_seq_tb;
    import pcmhc_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, en_i = 1'b1, cmd_valid_i = 1'b0;
    logic        wr_valid_i = 1'b1, cmd_ready_o, wr_ready_o, done_o;
    logic        ce_n_o, oe_n_o, we_n_o, dq_oe_n_o;
    logic [15:0] wr_data_i = 16'h0100, rdata_o, dq_o, dq_i;
    logic [22:0] addr_o;
    logic [7:0]  status_o;
    pcmhc_cmd_s  cmd_i = '0;
    pcmhc_res_s  res_o;
    int          err_total = 0, samples_checked = 0, cyc = 0, w0;
    wire  [15:0] res_w = {12'h000, res_o};
    wire  [15:0] rej_w = {15'h0000, res_o.rejected};
    pcmhc_seq #(.POLL_LIMIT(8)) pcmhc_seq_inst (.clk_i, .rst_i, .en_i, .cmd_valid_i,
        .cmd_i, .cmd_ready_o, .wr_valid_i, .wr_data_i, .wr_ready_o, .done_o, .res_o,
        .status_o, .rdata_o, .ce_n_o, .oe_n_o, .we_n_o, .addr_o, .dq_o, .dq_oe_n_o, .dq_i);
    pcmhc_mem_model mem_inst (.clk_i, .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
        .a_i(addr_o), .d_i(dq_o), .q_o(dq_i));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    // Buffer words advance on each take; the cycle ceiling cuts a hang short.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (wr_ready_o) wr_data_i <= wr_data_i + 16'h0001;
        if (cyc == 40000) close_out(1);
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input pcmhc_op_e op, input logic [22:0] a, input logic alt = 1'b0,
                       input logic [7:0] n = 8'h00);
        cmd_i <= '{op, alt, a, 16'h00c3, n};
        cmd_valid_i <= 1'b1;
        do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
        cmd_valid_i <= 1'b0;
        do @(posedge clk_i); while (done_o !== 1'b1);
    endtask
    task automatic close_out(input int e);
        err_total += e;
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Main sequence: each command is followed by its expected outcome.
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        run(OP_READ_STATUS, 23'h000100);
        chk({8'h00, status_o}, 16'h0080); // status read
        w0 = mem_inst.nwords;
        run(OP_BUF_PROG, 23'h010020, 1'b1, 8'h1f);
        chk(16'(mem_inst.nwords - w0), 16'h0020); // all words
        chk({8'h00, mem_inst.cntb}, 16'h001f); // count sent
        chk(res_w, 16'h0000); // clean finish
        chk({8'h00, mem_inst.last}, 16'h00ff); // array restore
        run(OP_BUF_PROG, 23'h020003);
        chk(res_w, 16'h0002); // unaligned
        w0 = mem_inst.nwr;
        run(OP_BUF_PROG, 23'h020000, 1'b0, 8'h20);
        chk(rej_w, 16'h0001); // count refused
        run(OP_BUF_PROG, 23'h02fffe, 1'b0, 8'h02);
        chk(rej_w, 16'h0001); // crossing refused
        chk(16'(mem_inst.nwr - w0), 16'h0000); // no bus writes
        run(OP_ERASE, 23'h030000);
        chk(res_w, 16'h0004); // poll timeout
        run(OP_SUSPEND, 23'h030000);
        chk(res_w, 16'h0001); // erase suspended
        run(OP_BUF_PROG, 23'h030000);
        chk(rej_w, 16'h0001); // busy block
        run(OP_READ, 23'h030004);
        chk(rej_w, 16'h0001); // busy block
        run(OP_READ, 23'h000005);
        chk(rdata_o, 16'h5550); // other block
        // The suspended flag reports the state at the time the resume was taken.
        run(OP_RESUME, 23'h000000);
        chk(res_w, 16'h0001); // resumed
        run(OP_SUSPEND, 23'h000000);
        chk(res_w, 16'h0000); // nothing to hold
        mem_inst.fail_nx = 1'b1;
        w0 = mem_inst.nclr;
        run(OP_WORD_PROG, 23'h000040, 1'b1);
        chk(16'(mem_inst.nclr - w0), 16'h0001); // error cleared
        run(OP_OTP_PROG, 23'h000080);
        chk(res_w, 16'h0000); // protection write
        close_out(0);
    end
endmodule

// ===== common/pcmhc_pkg.sv
// --------
// Shared constants and types of the memory command sequencer
// --------
package pcmhc_pkg;

    // Word address and data widths of the parallel memory bus.
    localparam int unsigned ADDR_W    = 23;
    localparam int unsigned DATA_W    = 16;
    // Word-address bits that lie inside one main block.
    localparam int unsigned BLOCK_LSB = 16;

    // Command codes written on the low data lines.
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
    localparam logic [7:0] CMD_WORD_PROG    = 8'h40;
    localparam logic [7:0] CMD_WORD_ALT     = 8'h42;
    localparam logic [7:0] CMD_BUF_PROG     = 8'he8;
    localparam logic [7:0] CMD_BUF_ALT      = 8'hea;
    localparam logic [7:0] CMD_ERASE        = 8'h20;
    localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_OTP_PROG     = 8'hc0;

    // Status bit positions and the error bits that need a clear-status.
    localparam int unsigned SR_READY_BIT    = 7;
    localparam int unsigned SR_SUSP_BIT     = 6;
    localparam logic [7:0]  SR_ERR_MASK     = 8'h3a;

    // Largest legal buffered word count minus one, and the alignment field.
    localparam logic [7:0]  BUF_MAX_COUNT   = 8'h1f;
    localparam int unsigned ALIGN_BITS      = 5;

    // Bus cycle phase lengths; least times round up to whole clocks.
    localparam int unsigned CLK_NS          = 8;
    localparam int unsigned T_SETUP_NS      = 10;
    localparam int unsigned T_WRITE_NS      = 60;
    localparam int unsigned T_READ_NS       = 140;
    localparam int unsigned T_HOLD_NS       = 20;
    localparam int unsigned SETUP_CYC       = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WRITE_CYC       = (T_WRITE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned READ_CYC        = (T_READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned HOLD_CYC        = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;

    // Default number of status reads before a poll gives up.
    localparam int unsigned POLL_LIMIT_DEF  = 100000;

    typedef enum logic [3:0] {
        OP_READ        = 4'h0,
        OP_WORD_PROG   = 4'h1,
        OP_BUF_PROG    = 4'h2,
        OP_ERASE       = 4'h3,
        OP_SUSPEND     = 4'h4,
        OP_RESUME      = 4'h5,
        OP_OTP_PROG    = 4'h6,
        OP_READ_STATUS = 4'h7,
        OP_CLEAR       = 4'h8,
        OP_ARRAY_MODE  = 4'h9
    } pcmhc_op_e;

    typedef struct packed {
        pcmhc_op_e           op;
        logic                alt;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
        logic [7:0]          count;
    } pcmhc_cmd_s;

    typedef struct packed {
        logic rejected;
        logic timeout;
        logic unaligned;
        logic suspended;
    } pcmhc_res_s;

    typedef struct packed {
        logic                write;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } pcmhc_req_s;

endpackage

// ===== verilog/pcmhc_bus_cycle.sv
`timescale 1ns/100ps
// --------
// One asynchronous bus cycle: setup, strobe, hold
// --------
module pcmhc_bus_cycle
    import pcmhc_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              en_i,
    input  wire logic              start_i,
    input  wire pcmhc_req_s        req_i,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic                   done_o,
    output logic [DATA_W-1:0]      rdata_o,
    output logic                   ce_n_o,
    output logic                   oe_n_o,
    output logic                   we_n_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [DATA_W-1:0]      dq_o,
    output logic                   dq_oe_n_o
);

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_SETUP = 2'b01,
        PH_PULSE = 2'b10,
        PH_HOLD  = 2'b11
    } pcmhc_phase_e;

    pcmhc_phase_e ph_q;
    logic [7:0]   cnt_q;
    logic         write_q;
    wire          cnt_zero = (cnt_q == 8'h00);

    // Chip enable rises after every cycle, so each read is a fresh strobe.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_q      <= PH_IDLE;
            cnt_q     <= 8'h00;
            write_q   <= 1'b0;
            done_o    <= 1'b0;
            rdata_o   <= '0;
            ce_n_o    <= 1'b1;
            oe_n_o    <= 1'b1;
            we_n_o    <= 1'b1;
            addr_o    <= '0;
            dq_o      <= '0;
            dq_oe_n_o <= 1'b1;
        end else if (en_i) begin
            done_o <= 1'b0;
            case (ph_q)
                PH_IDLE: begin
                    if (start_i) begin
                        addr_o    <= req_i.addr;
                        dq_o      <= req_i.data;
                        write_q   <= req_i.write;
                        ce_n_o    <= 1'b0;
                        dq_oe_n_o <= ~req_i.write;
                        cnt_q     <= 8'(SETUP_CYC - 1);
                        ph_q      <= PH_SETUP;
                    end
                end
                PH_SETUP: begin
                    if (cnt_zero) begin
                        we_n_o <= ~write_q;
                        oe_n_o <= write_q;
                        cnt_q  <= write_q ? 8'(WRITE_CYC - 1) : 8'(READ_CYC - 1);
                        ph_q   <= PH_PULSE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                PH_PULSE: begin
                    if (cnt_zero) begin
                        we_n_o <= 1'b1;
                        oe_n_o <= 1'b1;
                        if (!write_q) begin
                            rdata_o <= dq_i;
                        end
                        cnt_q <= 8'(HOLD_CYC - 1);
                        ph_q  <= PH_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                PH_HOLD: begin
                    if (cnt_zero) begin
                        ce_n_o    <= 1'b1;
                        dq_oe_n_o <= 1'b1;
                        done_o    <= 1'b1;
                        ph_q      <= PH_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: ph_q <= PH_IDLE;
            endcase
        end
    end

endmodule

// ===== verilog/pcmhc_seq.sv
`timescale 1ns/100ps
// How it works
// R01: Buffered program opens with E8H/EAH at block.
// R02: Poll status ready bit before going on.
// R03: Send count minus one; refuse above 1Fh.
// R04: First word at start, then remaining words.
// R05: Confirm D0H to block starts programming.
// R06: Device aborts data outside starting block.
// R07: Improper sequence flagged; host then clears status.
// R08: Start address ideally aligned to buffer boundary.
// R09: Write FFh after each operation ends. The code skips it after reads, status reads and clear-status.
// R10: Code 70h makes device drive status.
// R11: Code B0H suspends program or erase.
// R12: Status refreshes only on new strobe.
// R13: After suspend, bit 6 tells suspended or done.
// R14: During suspend, only other blocks read/programmed.
// R15: Resume with D0h anywhere, then poll.
// R16: Protection program: C0, data, poll ready.
// R17: Device errors protection writes outside space.
// R18: Device flags supply, program, lock errors.
// R19: Error bits stay until clear-status 50H.
// R20: Device enters setup states on program/erase codes.
// R21: Device stays ready on read and status codes.
module pcmhc_seq
    import pcmhc_pkg::*;
#(
    parameter int unsigned POLL_LIMIT = POLL_LIMIT_DEF
)(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              en_i,
    input  wire logic              cmd_valid_i,
    input  wire pcmhc_cmd_s        cmd_i,
    output logic                   cmd_ready_o,
    input  wire logic              wr_valid_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    output logic                   wr_ready_o,
    output logic                   done_o,
    output pcmhc_res_s             res_o,
    output logic [7:0]             status_o,
    output logic [DATA_W-1:0]      rdata_o,
    output logic                   ce_n_o,
    output logic                   oe_n_o,
    output logic                   we_n_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [DATA_W-1:0]      dq_o,
    output logic                   dq_oe_n_o,
    input  wire logic [DATA_W-1:0] dq_i
);

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_CMD     = 4'h1,
        ST_BUF_CHK = 4'h2,
        ST_COUNT   = 4'h3,
        ST_DATA    = 4'h4,
        ST_CONFIRM = 4'h5,
        ST_POLL    = 4'h6,
        ST_CLEAR   = 4'h7,
        ST_EXIT    = 4'h8,
        ST_READ    = 4'h9,
        ST_DONE    = 4'ha
    } pcmhc_state_e;

    localparam int unsigned PW = $clog2(POLL_LIMIT + 1);

    pcmhc_state_e      st_q;
    pcmhc_cmd_s        cmd_q;
    pcmhc_req_s        req_q;
    pcmhc_res_s        res_q;
    logic              pend_q;
    logic              start_q;
    logic [7:0]        idx_q;
    logic [PW-1:0]     polls_q;
    logic              susp_q;
    logic [ADDR_W-1:0] erase_blk_q;
    logic              bus_done;
    logic [DATA_W-1:0] bus_rdata;

    // --------
    // Decoding of the held command
    // --------

    // Block base of the target and of the request; data words stay inside it.
    wire [ADDR_W-1:0] blk_addr   = {cmd_q.addr[ADDR_W-1:BLOCK_LSB], {BLOCK_LSB{1'b0}}};
    wire [ADDR_W-1:0] in_blk     = {cmd_i.addr[ADDR_W-1:BLOCK_LSB], {BLOCK_LSB{1'b0}}};
    wire [ADDR_W-1:0] last_addr  = cmd_i.addr + ADDR_W'(cmd_i.count);
    wire              is_buf     = (cmd_q.op == OP_BUF_PROG);
    wire              in_buf     = (cmd_i.op == OP_BUF_PROG);
    wire              ready_bit  = bus_rdata[SR_READY_BIT];
    wire              poll_out   = (polls_q >= PW'(POLL_LIMIT));
    wire              last_word  = (idx_q == cmd_q.count);

    // R01: buffered opening code
    wire [7:0] buf_code  = cmd_q.alt ? CMD_BUF_ALT : CMD_BUF_PROG;
    wire [7:0] word_code = cmd_q.alt ? CMD_WORD_ALT : CMD_WORD_PROG;
    // R10: status read code
    // R11: suspend code
    // R15: resume with confirm code
    wire [7:0] op_code =
        (cmd_q.op == OP_BUF_PROG)    ? buf_code :
        (cmd_q.op == OP_WORD_PROG)   ? word_code :
        (cmd_q.op == OP_ERASE)       ? CMD_ERASE :
        (cmd_q.op == OP_SUSPEND)     ? CMD_SUSPEND :
        (cmd_q.op == OP_RESUME)      ? CMD_CONFIRM :
        (cmd_q.op == OP_OTP_PROG)    ? CMD_OTP_PROG :
        (cmd_q.op == OP_READ_STATUS) ? CMD_READ_STATUS :
        (cmd_q.op == OP_CLEAR)       ? CMD_CLEAR_STATUS : CMD_READ_ARRAY;

    // Refusals at the command port, checked before any bus cycle.
    // R03: count range check
    wire bad_count = in_buf && (cmd_i.count > BUF_MAX_COUNT);
    // R06: never leave the block
    wire bad_span  = in_buf && (last_addr[ADDR_W-1:BLOCK_LSB] != cmd_i.addr[ADDR_W-1:BLOCK_LSB]);
    // R14: suspended block is off limits
    wire susp_blk  = susp_q && (in_blk == erase_blk_q);
    wire bad_susp  = susp_q && ((cmd_i.op == OP_BUF_PROG) || (cmd_i.op == OP_ERASE) ||
                     (cmd_i.op == OP_OTP_PROG) || (cmd_i.op == OP_SUSPEND) ||
                     (((cmd_i.op == OP_READ) || (cmd_i.op == OP_WORD_PROG)) && susp_blk));
    wire reject    = bad_count || bad_span || bad_susp;
    // R08: alignment is only reported
    wire unaligned = in_buf && (cmd_i.addr[ALIGN_BITS-1:0] != '0);

    // --------
    // Bus request selection for the current step
    // --------

    wire is_read  = (st_q == ST_POLL) || (st_q == ST_READ) || (st_q == ST_BUF_CHK);
    wire active   = (st_q != ST_IDLE) && (st_q != ST_DONE);
    wire need_wd  = (st_q == ST_DATA) && is_buf;
    wire launch   = active && !pend_q && !start_q && (!need_wd || wr_valid_i);

    // R04: words follow the start address
    wire [ADDR_W-1:0] data_addr = is_buf ? (cmd_q.addr + ADDR_W'(idx_q)) : cmd_q.addr;
    wire blk_step = (st_q == ST_COUNT) || (st_q == ST_CONFIRM) || is_read ||
                    ((st_q == ST_CMD) && (is_buf || (cmd_q.op == OP_ERASE)));
    wire [ADDR_W-1:0] next_addr =
        (st_q == ST_DATA) ? data_addr :
        (st_q == ST_READ) ? cmd_q.addr :
        blk_step          ? blk_addr : cmd_q.addr;
    // R03: count on low data lines
    // R05: confirm code after the buffer
    // R07: clear-status after an error
    // R09: back to array mode
    wire [DATA_W-1:0] next_data =
        (st_q == ST_CMD)     ? DATA_W'(op_code) :
        (st_q == ST_COUNT)   ? DATA_W'(cmd_q.count) :
        (st_q == ST_DATA)    ? (is_buf ? wr_data_i : cmd_q.data) :
        (st_q == ST_CONFIRM) ? DATA_W'(CMD_CONFIRM) :
        (st_q == ST_CLEAR)   ? DATA_W'(CMD_CLEAR_STATUS) :
        (st_q == ST_EXIT)    ? DATA_W'(CMD_READ_ARRAY) : '0;

    // Next step once the opening code has gone out.
    wire pcmhc_state_e after_cmd =
        (cmd_q.op == OP_BUF_PROG)    ? ST_BUF_CHK :
        ((cmd_q.op == OP_WORD_PROG) || (cmd_q.op == OP_OTP_PROG)) ? ST_DATA :
        (cmd_q.op == OP_ERASE)       ? ST_CONFIRM :
        ((cmd_q.op == OP_SUSPEND) || (cmd_q.op == OP_RESUME)) ? ST_POLL :
        ((cmd_q.op == OP_READ_STATUS) || (cmd_q.op == OP_READ)) ? ST_READ : ST_DONE;

    // --------
    // Bus launch handshake
    // --------

    // The request is frozen in a register so that a buffer word taken from
    // the user port cannot change underneath the running cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_q      <= '0;
            start_q    <= 1'b0;
            pend_q     <= 1'b0;
            wr_ready_o <= 1'b0;
        end else if (en_i) begin
            start_q    <= launch;
            wr_ready_o <= launch && need_wd;
            if (launch) begin
                req_q  <= '{write: !is_read, addr: next_addr, data: next_data};
                pend_q <= 1'b1;
            end else if (bus_done) begin
                pend_q <= 1'b0;
            end
        end
    end

    // --------
    // Command sequencer
    // --------

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q        <= ST_IDLE;
            cmd_q       <= '0;
            res_q       <= '0;
            idx_q       <= 8'h00;
            polls_q     <= '0;
            susp_q      <= 1'b0;
            erase_blk_q <= '0;
            cmd_ready_o <= 1'b1;
            done_o      <= 1'b0;
            res_o       <= '0;
            status_o    <= 8'h80;
            rdata_o     <= '0;
        end else if (en_i) begin
            done_o <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    polls_q <= '0;
                    idx_q   <= 8'h00;
                    if (cmd_valid_i && cmd_ready_o) begin
                        cmd_ready_o <= 1'b0;
                        cmd_q       <= cmd_i;
                        res_q       <= '{rejected: reject, timeout: 1'b0,
                                         unaligned: unaligned, suspended: susp_q};
                        st_q        <= reject ? ST_DONE : ST_CMD;
                        if (!reject && (cmd_i.op == OP_ERASE)) begin
                            erase_blk_q <= in_blk;
                        end
                        if (!reject && (cmd_i.op == OP_RESUME)) begin
                            susp_q <= 1'b0;
                        end
                    end
                end
                ST_CMD: begin
                    if (pend_q && bus_done) begin
                        st_q <= after_cmd;
                    end
                end
                // R02: wait for buffer ready
                ST_BUF_CHK: begin
                    if (pend_q && bus_done) begin
                        if (ready_bit) begin
                            st_q    <= ST_COUNT;
                            polls_q <= '0;
                        end else if (poll_out) begin
                            res_q.timeout <= 1'b1;
                            st_q          <= ST_EXIT;
                        end else begin
                            polls_q <= polls_q + PW'(1);
                            st_q    <= ST_CMD;
                        end
                    end
                end
                ST_COUNT: begin
                    if (pend_q && bus_done) begin
                        st_q <= ST_DATA;
                    end
                end
                // R04: load count plus one words
                // R16: data to the same location
                ST_DATA: begin
                    if (pend_q && bus_done) begin
                        if (!is_buf) begin
                            st_q <= ST_POLL;
                        end else if (last_word) begin
                            st_q <= ST_CONFIRM;
                        end else begin
                            idx_q <= idx_q + 8'h01;
                        end
                    end
                end
                ST_CONFIRM: begin
                    if (pend_q && bus_done) begin
                        st_q <= ST_POLL;
                    end
                end
                // R02: poll until ready
                // R12: each poll is a new strobe
                ST_POLL: begin
                    if (pend_q && bus_done) begin
                        status_o <= bus_rdata[7:0];
                        if (ready_bit) begin
                            // R13: suspended or already done
                            if (cmd_q.op == OP_SUSPEND) begin
                                susp_q          <= bus_rdata[SR_SUSP_BIT];
                                res_q.suspended <= bus_rdata[SR_SUSP_BIT];
                            end
                            // R19: errors stick until cleared
                            st_q <= ((bus_rdata[7:0] & SR_ERR_MASK) != 8'h00) ?
                                    ST_CLEAR : ST_EXIT;
                        end else if (poll_out) begin
                            res_q.timeout <= 1'b1;
                            st_q          <= ST_EXIT;
                        end else begin
                            polls_q <= polls_q + PW'(1);
                        end
                    end
                end
                ST_CLEAR: begin
                    if (pend_q && bus_done) begin
                        st_q <= ST_EXIT;
                    end
                end
                ST_EXIT: begin
                    if (pend_q && bus_done) begin
                        st_q <= ST_DONE;
                    end
                end
                ST_READ: begin
                    if (pend_q && bus_done) begin
                        rdata_o <= bus_rdata;
                        if (cmd_q.op == OP_READ_STATUS) begin
                            status_o <= bus_rdata[7:0];
                        end
                        st_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    done_o      <= 1'b1;
                    res_o       <= res_q;
                    cmd_ready_o <= 1'b1;
                    st_q        <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // --------
    // Pin driver
    // --------

    pcmhc_bus_cycle u_bus (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .en_i      (en_i),
        .start_i   (start_q),
        .req_i     (req_q),
        .dq_i      (dq_i),
        .done_o    (bus_done),
        .rdata_o   (bus_rdata),
        .ce_n_o    (ce_n_o),
        .oe_n_o    (oe_n_o),
        .we_n_o    (we_n_o),
        .addr_o    (addr_o),
        .dq_o      (dq_o),
        .dq_oe_n_o (dq_oe_n_o)
    );

endmodule
